// file: rtl/pll_digital_lock_detect.sv
// Function
// - Two-bit code selects anti-backlash pulse width.
// - Lock needs 5/16/64/255 consecutive in-window cycles.
// - In-window means edge gap below window.
// - Locked flag holds until gap exceeds loss threshold or detection is disabled.
// - Bit 4 selects high or narrower window.
// - Bit 3 disables digital lock detection.
// - Calibration clock divides reference by field.
// - Divider codes give 2, 4, 8, 16.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pll_lock_cfg.svh"

module pll_digital_lock_detect #(
  parameter int WIN_HI_CYC = `LOCK_WIN_HI_CYC,  // High-range window.
  parameter int WIN_LO_CYC = 1,                // Low-range window.
  parameter int LOSS_HI_CYC = 4,               // High-range loss gap.
  parameter int LOSS_LO_CYC = 2,               // Low-range loss gap.
  parameter int DIFF_MAX = 63                  // Gap saturation value.
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RDATA,
  input wire logic REF_EDGE_IN,
  input wire logic FB_EDGE_IN,
  output logic LOCK_FLAG,
  output logic IRQ,
  output logic CAL_CLK,
  output logic [12:0] ABL_WIDTH_PS,
  output logic CMOS_DC_OFFSET_EN,
  output logic VCO_CAL_START
);

  // ====================================================================
  // Input edges.
  logic ref_rise;  // Reference edge pulse, synchronised.
  logic fb_rise;   // Feedback edge pulse, synchronised.

  // Both comparator inputs come from pins, so each is synchronised.
  edge_sync u_ref_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .async_in(REF_EDGE_IN),
    .rise(ref_rise)
  );

  edge_sync u_fb_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .async_in(FB_EDGE_IN),
    .rise(fb_rise)
  );

  // ====================================================================
  // Registers.
  logic [7:0] abl_cfg_reg;   // Anti-backlash pulse code.
  logic [7:0] lock_cfg_reg;  // Lock detect and reference setup.
  logic [1:0] evt_reg;       // Sticky event flags.
  logic [1:0] evt_next;      // Next value of the sticky flags.
  logic [1:0] mask_reg;      // Interrupt enables.
  logic [7:0] rdata_reg;     // Read data, one cycle after the strobe.
  logic [7:0] rdata_next;    // Read data selected this cycle.
  logic [12:0] abl_ps_reg;   // Registered pulse width output.
  logic [12:0] abl_ps_next;  // Width looked up from the code.

  // Address decode.
  wire wr_abl = WR_STB && (ADDR == `ABL_CFG_ADDR);
  wire wr_cfg = WR_STB && (ADDR == `LOCK_CFG_ADDR);
  wire wr_mask = WR_STB && (ADDR == `EVT_MASK_ADDR);
  wire rd_evt = RD_STB && (ADDR == `EVT_STATUS_ADDR);

  // Configuration fields.
  wire [1:0] run_sel = lock_cfg_reg[`CFG_RUN_SEL_HI:`CFG_RUN_SEL_LO];
  wire range_low = lock_cfg_reg[`CFG_RANGE_LOW_BIT];
  wire detect_off = lock_cfg_reg[`CFG_DISABLE_BIT];
  wire [1:0] caldiv_sel = lock_cfg_reg[`CFG_CALDIV_HI:`CFG_CALDIV_LO];

  // Software writes; unmapped writes are dropped.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      abl_cfg_reg <= `ABL_CFG_RESET;
      lock_cfg_reg <= `LOCK_CFG_RESET;
      mask_reg <= 2'(`EVT_MASK_RESET);
    end else begin
      if (wr_abl) begin
        abl_cfg_reg <= {6'h00, WDATA[1:0]};
      end
      if (wr_cfg) begin
        lock_cfg_reg <= WDATA;
      end
      if (wr_mask) begin
        mask_reg <= WDATA[1:0];
      end
    end
  end

  // Pulse width lookup; codes 00 and 11 both give the middle width.
  always_comb begin
    unique case (abl_cfg_reg[1:0])
      2'b00: abl_ps_next = `ABL_PS_0;
      2'b01: abl_ps_next = `ABL_PS_1;
      2'b10: abl_ps_next = `ABL_PS_2;
      2'b11: abl_ps_next = `ABL_PS_3;
    endcase
  end

  // The width output is a data output, so it comes from a flop.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      abl_ps_reg <= `ABL_PS_0;
    end else begin
      abl_ps_reg <= abl_ps_next;
    end
  end

  // ====================================================================
  // Phase comparison: pair each reference edge with a feedback edge.
  pll_lock_pkg::meas_state_e state_reg;  // Pairing state.
  pll_lock_pkg::meas_state_e state_next; // Next pairing state.
  pll_lock_pkg::diff_t gap_reg;          // Cycles since the first edge.
  pll_lock_pkg::diff_t gap_next;         // Next gap count.
  pll_lock_pkg::diff_t diff_reg;         // Gap of the finished cycle.
  pll_lock_pkg::diff_t diff_next;        // Next finished gap.
  logic done_reg;                        // One comparison finished.
  logic done_next;                       // Next finished pulse.

  localparam pll_lock_pkg::diff_t GAP_MAX = DIFF_MAX[7:0];

  // Edge that ends the wait, and edge that repeats the first one.
  wire other_edge = (state_reg == pll_lock_pkg::MEAS_WAIT_FB) ?
                    fb_rise : ref_rise;
  wire same_edge = (state_reg == pll_lock_pkg::MEAS_WAIT_FB) ?
                   ref_rise : fb_rise;

  // A missing edge shows as a saturated gap, which always counts as
  // out of window, so a dead feedback path cannot hold lock.
  always_comb begin
    state_next = state_reg;
    gap_next = gap_reg;
    diff_next = diff_reg;
    done_next = 1'b0;
    unique case (state_reg)
      pll_lock_pkg::MEAS_IDLE: begin
        gap_next = 8'h01;
        if (ref_rise && fb_rise) begin
          done_next = 1'b1;
          diff_next = 8'h00;
        end else if (ref_rise) begin
          state_next = pll_lock_pkg::MEAS_WAIT_FB;
        end else if (fb_rise) begin
          state_next = pll_lock_pkg::MEAS_WAIT_REF;
        end
      end
      pll_lock_pkg::MEAS_WAIT_FB, pll_lock_pkg::MEAS_WAIT_REF: begin
        if (other_edge) begin
          done_next = 1'b1;
          diff_next = gap_reg;
          state_next = pll_lock_pkg::MEAS_IDLE;
        end else if (same_edge || gap_reg == GAP_MAX) begin
          done_next = 1'b1;
          diff_next = GAP_MAX;
          gap_next = 8'h01;
          if (!same_edge) begin
            state_next = pll_lock_pkg::MEAS_IDLE;
          end
        end else begin
          gap_next = gap_reg + 8'h01;
        end
      end
      default: state_next = pll_lock_pkg::MEAS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_reg <= pll_lock_pkg::MEAS_IDLE;
      gap_reg <= 8'h00;
      diff_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      gap_reg <= gap_next;
      diff_reg <= diff_next;
      done_reg <= done_next;
    end
  end

  // ====================================================================
  // Lock decision with hysteresis.
  logic lock_reg;                        // Digital lock flag.
  logic lock_next;                       // Next lock flag.
  logic [7:0] run_reg;                   // Unbroken in-window cycles.
  logic [7:0] run_next;                  // Next run count.
  logic [7:0] run_target;                // Run length needed for lock.

  // Window and loss threshold follow the range bit.
  wire [7:0] win_cyc = range_low ? WIN_LO_CYC[7:0] :
                       WIN_HI_CYC[7:0];
  wire [7:0] loss_cyc = range_low ? LOSS_LO_CYC[7:0] :
                        LOSS_HI_CYC[7:0];
  wire in_win = diff_reg < win_cyc;
  wire over_loss = diff_reg > loss_cyc;

  always_comb begin
    unique case (run_sel)
      2'b00: run_target = `RUN_CNT_0;
      2'b01: run_target = `RUN_CNT_1;
      2'b10: run_target = `RUN_CNT_2;
      2'b11: run_target = `RUN_CNT_3;
    endcase
  end

  // Unlocked, the run grows on each in-window cycle; locked, only the
  // larger loss gap or the disable bit drops the flag, so jitter near the window edge
  // does not make the flag chatter.
  always_comb begin
    lock_next = lock_reg;
    run_next = run_reg;
    if (detect_off) begin
      lock_next = 1'b0;
      run_next = 8'h00;
    end else if (done_reg && !lock_reg) begin
      if (!in_win) begin
        run_next = 8'h00;
      end else if (run_reg >= run_target - 8'h01) begin
        lock_next = 1'b1;
        run_next = 8'h00;
      end else begin
        run_next = run_reg + 8'h01;
      end
    end else if (done_reg && over_loss) begin
      lock_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      lock_reg <= 1'b0;
      run_reg <= 8'h00;
    end else begin
      lock_reg <= lock_next;
      run_reg <= run_next;
    end
  end

  // ====================================================================
  // Events, interrupt and read-back.
  wire lock_gain = lock_next && !lock_reg;
  wire lock_drop = !lock_next && lock_reg;

  // A new event in the clearing read's cycle survives the clear.
  always_comb begin
    evt_next = rd_evt ? 2'h0 : evt_reg;
    evt_next[`EVT_LOCKED_BIT] = evt_next[`EVT_LOCKED_BIT] | lock_gain;
    evt_next[`EVT_LOST_BIT] = evt_next[`EVT_LOST_BIT] | lock_drop;
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    unique case (ADDR)
      `ABL_CFG_ADDR: rdata_next = abl_cfg_reg;
      `LOCK_CFG_ADDR: rdata_next = lock_cfg_reg;
      `EVT_STATUS_ADDR: rdata_next = {6'h00, evt_reg};
      `EVT_MASK_ADDR: rdata_next = {6'h00, mask_reg};
      `LIVE_STATUS_ADDR: rdata_next = {7'h00, lock_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      evt_reg <= 2'h0;
      rdata_reg <= 8'h00;
    end else begin
      evt_reg <= evt_next;
      rdata_reg <= RD_STB ? rdata_next : 8'h00;
    end
  end

  // ====================================================================
  // Calibration clock.
  cal_clk_divider u_cal_div (
    .clk(CLK_SYS),
    .rst(RESET),
    .ref_rise(ref_rise),
    .ratio_sel(caldiv_sel),
    .cal_clk(CAL_CLK)
  );

  assign RDATA = rdata_reg;
  assign LOCK_FLAG = lock_reg;
  assign IRQ = |(evt_reg & mask_reg);
  assign ABL_WIDTH_PS = abl_ps_reg;
  assign CMOS_DC_OFFSET_EN = lock_cfg_reg[`CFG_DC_OFFSET_BIT];
  assign VCO_CAL_START = lock_cfg_reg[`CFG_CAL_NOW_BIT];

  // ====================================================================
  // Checks.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_locked_ok;
    lock_reg && done_reg && !over_loss && !detect_off;
  endsequence

  sequence s_miss;
    done_reg && !in_win && !lock_reg && !detect_off;
  endsequence

  AST_ABL_CODE: assert property (abl_cfg_reg[1:0] == 2'b10 |=>
    ABL_WIDTH_PS == `ABL_PS_2) else $error("Pulse width wrong.");
  AST_RUN_LEN: assert property ($rose(lock_reg) |->
    $past(run_reg) == $past(run_target) - 8'h01)
    else $error("Lock after wrong run length.");
  AST_WIN_GAP: assert property ($rose(lock_reg) |->
    $past(done_reg && diff_reg < win_cyc)) else $error("Lock off window.");
  AST_HOLD: assert property (s_locked_ok |=> lock_reg)
    else $error("Lock dropped inside loss gap.");
  AST_LOSS: assert property (lock_reg && done_reg && over_loss
    && !detect_off |=> !lock_reg) else $error("Loss not seen.");
  AST_LOW_RANGE: assert property (range_low && done_reg &&
    diff_reg >= WIN_LO_CYC[7:0] && !lock_reg |=> !lock_reg)
    else $error("Low range ignored.");
  AST_DISABLE: assert property (detect_off |=> !lock_reg &&
    run_reg == 8'h00) else $error("Detect not disabled.");
  AST_CAL_EDGE: assert property ($changed(CAL_CLK) |->
    $past(ref_rise)) else $error("Calibration clock moved alone.");
  AST_RUN_CLR: assert property (s_miss |=> run_reg == 8'h00)
    else $error("Run not cleared.");

endmodule : pll_digital_lock_detect

`default_nettype wire

// file: rtl/pll_lock_cfg.svh
`ifndef PLL_LOCK_CFG_SVH
`define PLL_LOCK_CFG_SVH

// ======================================================================
// Register map.
`define ABL_CFG_ADDR 8'h17
`define LOCK_CFG_ADDR 8'h18
`define EVT_STATUS_ADDR 8'h40
`define EVT_MASK_ADDR 8'h41
`define LIVE_STATUS_ADDR 8'h42

// ======================================================================
// Reset values.
`define ABL_CFG_RESET 8'h00
`define LOCK_CFG_RESET 8'h06
`define EVT_MASK_RESET 8'h00

// ======================================================================
// Field positions in the lock configuration register.
`define CFG_DC_OFFSET_BIT 7
`define CFG_RUN_SEL_HI 6
`define CFG_RUN_SEL_LO 5
`define CFG_RANGE_LOW_BIT 4
`define CFG_DISABLE_BIT 3
`define CFG_CALDIV_HI 2
`define CFG_CALDIV_LO 1
`define CFG_CAL_NOW_BIT 0

// Event bits in the status and mask registers.
`define EVT_LOCKED_BIT 0
`define EVT_LOST_BIT 1

// ======================================================================
// Consecutive in-window cycles needed for lock, per select code.
// The values are 5, 16, 64 and 255.
`define RUN_CNT_0 8'h05
`define RUN_CNT_1 8'h10
`define RUN_CNT_2 8'h40
`define RUN_CNT_3 8'hff

// Anti-backlash pulse widths in picoseconds, per select code.
// The values are 2900, 1300, 6000 and 2900.
`define ABL_PS_0 13'hb54
`define ABL_PS_1 13'h514
`define ABL_PS_2 13'h1770
`define ABL_PS_3 13'hb54

// Default high-range lock window, in picoseconds.
`define LOCK_WIN_HI_PS 3500
// System clock period in picoseconds.
`define CLK_SYS_PERIOD_PS 50000
// Window in whole clock cycles, rounded up, then plus one, never below two.
`define LOCK_WIN_HI_CYC \
  (((`LOCK_WIN_HI_PS + `CLK_SYS_PERIOD_PS - 1) / `CLK_SYS_PERIOD_PS) + 1)

`endif

// file: rtl/pll_lock_pkg.sv
`default_nettype none

package pll_lock_pkg;

  // Edge-pairing state of the phase comparison.
  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b00,
    MEAS_WAIT_FB = 2'b01,
    MEAS_WAIT_REF = 2'b10
  } meas_state_e;

  // Edge-to-edge distance in clock cycles.
  typedef logic [7:0] diff_t;

endpackage : pll_lock_pkg

`default_nettype wire

// file: rtl/edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Two-stage synchroniser with rising-edge detect on the second stage.
module edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic async_in,
  output logic rise
);

  logic meta_reg;  // First stage; read only by the second stage.
  logic sync_reg;  // Second stage, safe to use.
  logic prev_reg;  // Delayed copy for the edge detect.

  // Shift the pin through the chain.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // One-cycle pulse on each rising edge.
  assign rise = sync_reg & ~prev_reg;

endmodule : edge_sync

`default_nettype wire

// file: rtl/cal_clk_divider.sv
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Divides the reference edge stream by 2, 4, 8 or 16.
module cal_clk_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic ref_rise,
  input wire logic [1:0] ratio_sel,
  output logic cal_clk
);

  logic [2:0] edge_cnt_reg;  // Reference edges since the last toggle.
  logic cal_reg;             // Divided clock level.
  logic [2:0] half_last;     // Count at which the output toggles.

  // Half the ratio, less one: 0, 1, 3, 7 for codes 00 to 11.
  assign half_last = (3'h1 << ratio_sel) - 3'h1;

  // Toggle every half period; a ratio change takes effect cleanly
  // because the count is compared, not loaded.
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_cnt_reg <= 3'h0;
      cal_reg <= 1'b0;
    end else if (ref_rise) begin
      if (edge_cnt_reg >= half_last) begin
        edge_cnt_reg <= 3'h0;
        cal_reg <= ~cal_reg;
      end else begin
        edge_cnt_reg <= edge_cnt_reg + 3'h1;
      end
    end
  end

  assign cal_clk = cal_reg;

endmodule : cal_clk_divider

`default_nettype wire

// file: verification/pfd_edge_source.sv
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Stand-in for the reference and feedback dividers feeding the detector.
module pfd_edge_source #(
  parameter int PERIOD = 16  // Clock cycles between reference edges.
) (
  input wire logic clk,
  input wire logic run,
  input wire logic [3:0] gap,
  output logic ref_pin,
  output logic fb_pin
);
  logic [4:0] cnt_reg;  // Position inside the comparison period.
  logic [3:0] gap_reg;  // Feedback delay used in the current period.
  logic wrap;  // Last cycle of a period, or stopped.

  assign wrap = !run || (cnt_reg == 5'(PERIOD - 1));

  // The delay is only taken at a period boundary, so a change in
  // mid-period never splits or doubles a feedback pulse.
  always_ff @(posedge clk) begin
    cnt_reg <= wrap ? 5'h00 : cnt_reg + 5'h01;
    if (wrap) begin
      gap_reg <= gap;
    end
  end

  // Pulses are two cycles wide so the two-flop synchroniser sees them.
  // Both pins sit low while stopped, so no stray edge appears.
  assign ref_pin = run && (cnt_reg < 5'h02);
  assign fb_pin = run && (cnt_reg >= {1'b0, gap_reg}) &&
                  (cnt_reg < {1'b0, gap_reg} + 5'h02);
endmodule : pfd_edge_source

`default_nettype wire

// file: verification/tb_pll_digital_lock_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "pll_lock_cfg.svh"

// Compares one value, counts it, and reports a mismatch at once.
`define CHK(act, exp, msg) begin \
  cmp_count++; \
  if ((act) !== (exp)) begin \
    num_errors++; \
    $display("Error at %0t ns: %s", $time, msg); \
  end \
end

// ======================================================================
// Register-level bench for the digital lock detector.
module tb_pll_digital_lock_detect;
  logic CLK_SYS;
  logic RESET = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic [7:0] RDATA;
  logic REF_EDGE_IN;
  logic FB_EDGE_IN;
  logic LOCK_FLAG;
  logic IRQ;
  logic CAL_CLK;
  logic [12:0] ABL_WIDTH_PS;
  logic CMOS_DC_OFFSET_EN;
  logic VCO_CAL_START;
  logic run = 1'b0;  // Edge source running.
  logic [3:0] gap = 4'h1;  // Feedback delay in cycles.
  int num_errors = 0;
  int cmp_count = 0;
  int toggles;
  logic cal_prev;
  logic [7:0] rd;
  logic [12:0] abl_exp [4] = '{13'hb54, 13'h514, 13'h1770, 13'hb54};
  int run_len [4] = '{5, 16, 64, 255};
  int ratio [4] = '{2, 4, 8, 16};

  // ======================================================================
  // Clock at 20 MHz.
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  pll_digital_lock_detect DUT (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .REF_EDGE_IN(REF_EDGE_IN), .FB_EDGE_IN(FB_EDGE_IN),
    .LOCK_FLAG(LOCK_FLAG), .IRQ(IRQ), .CAL_CLK(CAL_CLK),
    .ABL_WIDTH_PS(ABL_WIDTH_PS), .CMOS_DC_OFFSET_EN(CMOS_DC_OFFSET_EN),
    .VCO_CAL_START(VCO_CAL_START)
  );

  pfd_edge_source u_edges (
    .clk(CLK_SYS), .run(run), .gap(gap),
    .ref_pin(REF_EDGE_IN), .fb_pin(FB_EDGE_IN)
  );

  // ======================================================================
  // Bus tasks: one-cycle strobes, read data taken in the following cycle.
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
  endtask : wr

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    #1;
    rd = RDATA;
    `CHK(rd, e, "read data differs")
  endtask : chk_rd

  // Stops the edges long enough for any open pair to time out, clears the
  // run by a disable pulse, then restarts from a known phase.
  task automatic restart(input logic [7:0] cfg);
    @(posedge CLK_SYS);
    run <= 1'b0;
    cyc(80);
    wr(`LOCK_CFG_ADDR, cfg | 8'h08);
    wr(`LOCK_CFG_ADDR, cfg);
    @(posedge CLK_SYS);
    run <= 1'b1;
  endtask : restart

  // Lock must appear after the n-th pair and not after the one before.
  task automatic expect_lock(input int n);
    cyc(16 * (n - 1));
    #1;
    `CHK(LOCK_FLAG, 1'b0, "lock too early") // Early lock.
    cyc(16);
    #1;
    `CHK(LOCK_FLAG, 1'b1, "lock missing") // Late lock.
  endtask : expect_lock

  task automatic report_and_stop;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ======================================================================
  // Main sequence.
  initial begin
    cyc(16);
    RESET <= 1'b0;
    #1;
    `CHK(ABL_WIDTH_PS, 13'hb54, "pulse width reset") // Default.
    `CHK(CMOS_DC_OFFSET_EN, 1'b0, "dc offset reset")
    `CHK(VCO_CAL_START, 1'b0, "cal start reset")
    `CHK(LOCK_FLAG, 1'b0, "lock at reset")
    chk_rd(`LOCK_CFG_ADDR, 8'h06); // Defaults.
    chk_rd(`ABL_CFG_ADDR, 8'h00); // Default code.
    chk_rd(8'h20, 8'h00);
    // Every pulse width code, then a write with upper bits set.
    for (int i = 0; i < 4; i++) begin
      wr(`ABL_CFG_ADDR, {6'h00, 2'(i)});
      cyc(2);
      #1;
      `CHK(ABL_WIDTH_PS, abl_exp[i], "pulse width") // Code table.
    end
    wr(`ABL_CFG_ADDR, 8'hfd);
    chk_rd(`ABL_CFG_ADDR, 8'h01); // Only the code is kept.
    // Lock on one-cycle gaps, just inside the high window.
    restart(8'h06);
    expect_lock(5); // Five pairs at gap one.
    `CHK(IRQ, 1'b0, "irq while masked")
    wr(`EVT_MASK_ADDR, 8'h01);
    cyc(2);
    #1;
    `CHK(IRQ, 1'b1, "irq missing")
    chk_rd(`EVT_STATUS_ADDR, 8'h01);
    cyc(2);
    #1;
    `CHK(IRQ, 1'b0, "irq not cleared")
    chk_rd(`EVT_STATUS_ADDR, 8'h00);
    chk_rd(`LIVE_STATUS_ADDR, 8'h01);
    // A gap equal to the loss limit keeps the flag; one more drops it.
    gap <= 4'h4;
    cyc(16 * 8);
    #1;
    `CHK(LOCK_FLAG, 1'b1, "hysteresis lost") // Held at gap four.
    gap <= 4'h5;
    cyc(16 * 3);
    #1;
    `CHK(LOCK_FLAG, 1'b0, "loss missed") // Dropped at gap five.
    `CHK(IRQ, 1'b0, "lost event not masked")
    wr(`EVT_MASK_ADDR, 8'h02);
    cyc(2);
    #1;
    `CHK(IRQ, 1'b1, "lost event irq missing")
    chk_rd(`EVT_STATUS_ADDR, 8'h02); // Loss event.
    // One pair at gap two, on the window edge, must restart the run.
    // The delay is set first so the very first pair already uses it.
    gap <= 4'h1;
    restart(8'h06);
    cyc(16 * 3 + 8);
    gap <= 4'h2;
    cyc(16);
    gap <= 4'h1;
    cyc(16 * 2);
    #1;
    `CHK(LOCK_FLAG, 1'b0, "run not cleared") // Broken run.
    cyc(16 * 4);
    #1;
    `CHK(LOCK_FLAG, 1'b1, "relock missing") // Fresh run.
    // Longer run lengths.
    for (int s = 1; s < 4; s++) begin
      restart({1'b0, 2'(s), 5'h06});
      expect_lock(run_len[s]); // Run select codes.
    end
    // Narrow range refuses gap one but accepts gap zero.
    restart(8'h16);
    cyc(16 * 8);
    #1;
    `CHK(LOCK_FLAG, 1'b0, "narrow window") // Gap one is outside.
    gap <= 4'h0;
    cyc(16 * 7);
    #1;
    `CHK(LOCK_FLAG, 1'b1, "narrow lock") // Gap zero is inside.
    // Disable with good edges still arriving.
    wr(`LOCK_CFG_ADDR, 8'h1e);
    cyc(3);
    #1;
    `CHK(LOCK_FLAG, 1'b0, "disable ignored") // Off at once.
    cyc(16 * 8);
    #1;
    `CHK(LOCK_FLAG, 1'b0, "lock while off") // Stays off.
    // Calibration clock toggle count over a window of sixteen periods.
    for (int i = 0; i < 4; i++) begin
      wr(`LOCK_CFG_ADDR, {5'h00, 2'(i), 1'b0});
      cyc(16 * 32);
      #1;
      toggles = 0;
      cal_prev = CAL_CLK;
      repeat (256) begin
        @(posedge CLK_SYS);
        #1;
        if (CAL_CLK !== cal_prev) toggles++;
        cal_prev = CAL_CLK;
      end
      `CHK(toggles, 32 / ratio[i], "cal divider") // Ratios.
    end
    // Plain configuration bits reach their outputs.
    wr(`LOCK_CFG_ADDR, 8'h81);
    cyc(1);
    #1;
    `CHK(CMOS_DC_OFFSET_EN, 1'b1, "dc offset bit")
    `CHK(VCO_CAL_START, 1'b1, "cal start bit")
    report_and_stop();
  end

  // Watchdog well beyond the roughly 10000 cycles the tests need.
  initial begin
    cyc(40000);
    num_errors++;
    $display("Error at %0t ns: watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb_pll_digital_lock_detect

`default_nettype wire
